/* src/subx_pkg.sv */
package subx_pkg;

   // instruction selector presented by the decoder
   typedef enum logic [3:0] {
      op_none,
      op_literal_minus_acc,
      op_file_minus_acc,
      op_file_minus_acc_borrow,
      op_nibble_exchange,
      op_direction_load,
      op_literal_exclusive_or,
      op_file_exclusive_or,
      op_sleep
   } op_t;

   localparam int data_w = 8;
   localparam int addr_w = 7;
   localparam int file_depth = 128;
   localparam int wdt_w = 8;
   localparam int pre_w = 8;

   // direction-load operand codes
   localparam logic [2:0] dir_sel_a = 3'h5;
   localparam logic [2:0] dir_sel_b = 3'h6;
   localparam logic [2:0] dir_sel_c = 3'h7;

   // reset values
   localparam logic [7:0] acc_rst = 8'h00;
   localparam logic [7:0] dir_rst = 8'hff;
   localparam logic [7:0] wdt_clear = 8'h00;
   localparam logic [7:0] pre_clear = 8'h00;

   // nibble positions
   localparam int nib_lo_top = 3;
   localparam int nib_hi_bot = 4;

   // one decoded instruction
   typedef struct packed {
      op_t op;
      logic [7:0] literal;
      logic [6:0] addr;
      logic dest_file;
   } instr_t;

   // arithmetic status flags
   typedef struct packed {
      logic carry;
      logic half_borrow_flag;
      logic zero;
   } flags_t;

endpackage

/* src/file_ram.sv */
`timescale 1ns/1ps
module file_ram
   import subx_pkg::*;
#(
   parameter int depth = file_depth,
   parameter int aw = addr_w,
   parameter int dw = data_w
) (
   // clock
   input wire logic clock,
   // read port, registered data
   input wire logic [aw-1:0] rd_addr,
   output logic [dw-1:0] rd_data,
   // write port
   input wire logic wr_en,
   input wire logic [aw-1:0] wr_addr,
   input wire logic [dw-1:0] wr_data
);

   // starts cleared so a first read is defined; real cells may power up random
   logic [dw-1:0] mem [depth] = '{default: '0};

   // write first so a same-cycle read sees the new byte
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (wr_en && wr_addr == rd_addr) begin
         rd_data <= wr_data;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

/* src/subx_exec.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// RL1: literal_minus_acc puts literal minus accumulator into the accumulator.
// RL2: subtract sets carry, half_borrow_flag, zero; carry 0 if acc larger.
// RL3: sleep zeroes watchdog counter and prescaler, then halts with clock off.
// RL4: sleep sets expiry_flag_n to one and clears power_down_flag_n.
// RL5: file_minus_acc subtracts accumulator from file byte at 7-bit address.
// RL6: destination bit 0 writes accumulator, 1 writes the file register.
// RL7: borrow subtract is file minus acc minus inverted carry, flags updated.
// RL8: nibble_exchange swaps file nibbles into destination, flags untouched.
// RL9: direction_load copies acc to port a, b, c direction for 5, 6, 7.
// RL10: literal_exclusive_or xors acc with literal into acc, zero only.
// RL11: file_exclusive_or xors acc with file byte to destination, zero only.
// RL12: zero flag set when the 8-bit result is zero, cleared otherwise.
module subx_exec
   import subx_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // instruction from the decoder
   input wire logic instr_valid,
   input wire instr_t instr,
   output logic instr_ready,
   // wake request ends sleep
   input wire logic wake,
   // watchdog tick from the timer logic
   input wire logic wdt_tick,
   // architectural state
   output logic [data_w-1:0] acc,
   output flags_t flags,
   output logic expiry_flag_n,
   output logic power_down_flag_n,
   output logic [data_w-1:0] port_a_direction,
   output logic [data_w-1:0] port_b_direction,
   output logic [data_w-1:0] port_c_direction,
   output logic [wdt_w-1:0] watchdog_counter,
   output logic [pre_w-1:0] wdt_prescaler,
   // core state
   output logic sleeping,
   output logic osc_stop,
   output logic busy
);

   typedef enum logic [1:0] {st_idle, st_fetch, st_sleep} state_t;

   state_t state_r, state_nxt;
   instr_t held_r;
   logic [data_w-1:0] acc_r;
   flags_t flags_r;
   logic expiry_r, down_r;
   logic [data_w-1:0] dir_a_r, dir_b_r, dir_c_r;
   logic [wdt_w-1:0] wdt_r;
   logic [pre_w-1:0] pre_r;
   logic [data_w-1:0] file_q;

   ////////////////////////////////////////////////////////////////////////
   // operand selection and arithmetic
   wire logic is_fetch = (state_r == st_fetch);
   wire op_t op = held_r.op;
   wire logic lit_op = (op == op_literal_minus_acc) ||
                       (op == op_literal_exclusive_or);
   wire logic [data_w-1:0] opnd = lit_op ? held_r.literal : file_q;
   wire logic sub_op = (op == op_literal_minus_acc) ||
                       (op == op_file_minus_acc) ||
                       (op == op_file_minus_acc_borrow);
   // borrow in is the inverted carry, only for the borrow form
   wire logic borrow_in = (op == op_file_minus_acc_borrow) ?
                          ~flags_r.carry : 1'b0; // RL7
   // 9-bit sum: opnd + ~acc + carry_in, bit 8 is carry (no borrow)
   wire logic [data_w:0] diff = {1'b0, opnd} + {1'b0, ~acc_r} +
                                {8'h00, ~borrow_in}; // RL1 RL5 RL7
   wire logic [4:0] diff_lo = {1'b0, opnd[nib_lo_top:0]} +
                              {1'b0, ~acc_r[nib_lo_top:0]} +
                              {4'h0, ~borrow_in}; // RL2
   wire logic [data_w-1:0] swapped =
      {file_q[nib_lo_top:0], file_q[data_w-1:nib_hi_bot]}; // RL8
   wire logic [data_w-1:0] xored = acc_r ^ opnd; // RL10 RL11

   // result select
   logic [data_w-1:0] result;
   always_comb begin
      case (op)
         op_literal_minus_acc,
         op_file_minus_acc,
         op_file_minus_acc_borrow: result = diff[data_w-1:0];
         op_nibble_exchange: result = swapped;
         op_literal_exclusive_or,
         op_file_exclusive_or: result = xored;
         default: result = acc_r;
      endcase
   end

   wire logic res_zero = (result == 8'h00); // RL12
   wire logic file_dest_op = (op == op_file_minus_acc) ||
                             (op == op_file_minus_acc_borrow) ||
                             (op == op_nibble_exchange) ||
                             (op == op_file_exclusive_or);
   wire logic to_file = is_fetch && file_dest_op && held_r.dest_file; // RL6
   wire logic to_acc = is_fetch && !to_file &&
                       (lit_op || file_dest_op); // RL6
   wire logic upd_cz = is_fetch && sub_op; // RL2
   wire logic upd_z = is_fetch && (sub_op ||
                      op == op_literal_exclusive_or ||
                      op == op_file_exclusive_or); // RL10 RL11
   wire logic dir_op = is_fetch && (op == op_direction_load);
   wire logic go_sleep = is_fetch && (op == op_sleep);

   ////////////////////////////////////////////////////////////////////////
   // file register memory; read address taken from the incoming word
   wire logic take = instr_ready && instr_valid;
   file_ram #(
      .depth(file_depth),
      .aw(addr_w),
      .dw(data_w)
   ) u_ram (
      .clock(clock),
      .rd_addr(instr.addr),
      .rd_data(file_q),
      .wr_en(to_file),
      .wr_addr(held_r.addr),
      .wr_data(result)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencer: accept, execute one cycle later when the ram data lands
   always_comb begin
      case (state_r)
         st_idle: state_nxt = take ? st_fetch : st_idle;
         st_fetch: begin
            if (go_sleep) begin
               state_nxt = st_sleep; // RL3
            end else begin
               state_nxt = take ? st_fetch : st_idle;
            end
         end
         st_sleep: state_nxt = wake ? st_idle : st_sleep;
         default: state_nxt = st_idle;
      endcase
   end

   // no new word while sleeping or while sleep is being taken
   assign instr_ready = (state_r == st_idle) ||
                        (is_fetch && !go_sleep);

   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         held_r <= '0;
      end else if (take) begin
         held_r <= instr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // accumulator and flags
   always_ff @(posedge clock) begin
      if (rst) begin
         acc_r <= acc_rst;
      end else if (to_acc) begin
         acc_r <= result; // RL1 RL6 RL10
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         flags_r <= '0;
      end else begin
         if (upd_cz) begin
            flags_r.carry <= diff[data_w]; // RL2
            flags_r.half_borrow_flag <= diff_lo[4]; // RL2
         end
         if (upd_z) begin
            flags_r.zero <= res_zero; // RL12
         end
      end
   end

   // status bits start as after power-on: both inactive-high
   always_ff @(posedge clock) begin
      if (rst) begin
         expiry_r <= 1'b1;
         down_r <= 1'b1;
      end else if (go_sleep) begin
         expiry_r <= 1'b1; // RL4
         down_r <= 1'b0; // RL4
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // direction registers, one per port
   always_ff @(posedge clock) begin
      if (rst) begin
         dir_a_r <= dir_rst;
         dir_b_r <= dir_rst;
         dir_c_r <= dir_rst;
      end else if (dir_op) begin
         // other operand codes are ignored
         case (held_r.addr[2:0])
            dir_sel_a: dir_a_r <= acc_r; // RL9
            dir_sel_b: dir_b_r <= acc_r; // RL9
            dir_sel_c: dir_c_r <= acc_r; // RL9
            default: dir_a_r <= dir_a_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog: prescaler then counter; frozen while the oscillator is off
   wire logic pre_wrap = (pre_r == {pre_w{1'b1}});
   always_ff @(posedge clock) begin
      if (rst || go_sleep) begin
         pre_r <= pre_clear; // RL3
         wdt_r <= wdt_clear; // RL3
      end else if (wdt_tick && state_r != st_sleep) begin
         pre_r <= pre_r + 8'h01;
         if (pre_wrap) begin
            wdt_r <= wdt_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign acc = acc_r;
   assign flags = flags_r;
   assign expiry_flag_n = expiry_r;
   assign power_down_flag_n = down_r;
   assign port_a_direction = dir_a_r;
   assign port_b_direction = dir_b_r;
   assign port_c_direction = dir_c_r;
   assign watchdog_counter = wdt_r;
   assign wdt_prescaler = pre_r;
   assign sleeping = (state_r == st_sleep); // RL3
   assign osc_stop = (state_r == st_sleep); // RL3
   assign busy = is_fetch;

endmodule

/* bench/subx_exec_chk.sv */
`timescale 1ns/1ps
module subx_exec_chk
   import subx_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // request
   input wire logic instr_valid,
   input wire instr_t instr,
   input wire logic instr_ready,
   // results
   input wire logic [data_w-1:0] acc,
   input wire flags_t flags,
   input wire logic expiry_flag_n,
   input wire logic power_down_flag_n,
   input wire logic [data_w-1:0] port_a_direction,
   input wire logic [wdt_w-1:0] watchdog_counter,
   input wire logic [pre_w-1:0] wdt_prescaler,
   input wire logic sleeping
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // results land two samples after the take edge
   wire tk = instr_valid && instr_ready;
   wire tk_sl = tk && instr.op == op_sleep;
   wire tk_ls = tk && instr.op == op_literal_minus_acc;
   property p_sleep_status;
      tk_sl |-> ##2 expiry_flag_n && !power_down_flag_n;
   endproperty
   a_sleep_status: assert property (p_sleep_status)
      else $error("sleep status bits wrong");
   property p_sleep_clear;
      tk_sl |-> ##2 sleeping && watchdog_counter == wdt_clear
         && wdt_prescaler == pre_clear;
   endproperty
   a_sleep_clear: assert property (p_sleep_clear)
      else $error("sleep did not clear watchdog");
   property p_no_take_asleep;
      sleeping |-> !instr_ready;
   endproperty
   a_no_take_asleep: assert property (p_no_take_asleep)
      else $error("request accepted while asleep");
   property p_lit_sub;
      tk_ls |-> ##2 acc == $past(instr.literal, 2) - $past(acc);
   endproperty
   a_lit_sub: assert property (p_lit_sub)
      else $error("literal subtract result wrong");
   property p_sub_flags;
      tk_ls |-> ##2 flags.carry == ($past(acc) <= $past(instr.literal, 2))
         && flags.half_borrow_flag == ($past(acc[3:0])
         <= $past(instr.literal[3:0], 2)) && flags.zero == (acc == 0);
   endproperty
   a_sub_flags: assert property (p_sub_flags)
      else $error("subtract flags wrong");
   property p_lit_xor;
      tk && instr.op == op_literal_exclusive_or |-> ##2
         flags.zero == (acc == 0)
         && acc == ($past(instr.literal, 2) ^ $past(acc))
         && flags.carry == $past(flags.carry);
   endproperty
   a_lit_xor: assert property (p_lit_xor)
      else $error("literal xor wrong");
   property p_dir_a;
      tk && instr.op == op_direction_load && instr.addr[2:0] == dir_sel_a
         |-> ##2 port_a_direction == $past(acc);
   endproperty
   a_dir_a: assert property (p_dir_a)
      else $error("port a direction not loaded");
   property p_file_dest;
      tk && instr.dest_file && instr.op inside {op_file_minus_acc,
         op_nibble_exchange, op_file_exclusive_or} |-> ##2 acc == $past(acc);
   endproperty
   a_file_dest: assert property (p_file_dest)
      else $error("file destination touched accumulator");
endmodule

/* bench/subtract_swap_xor_sleep_exec_tb_top.sv */
`timescale 1ns/1ps
module subtract_swap_xor_sleep_exec_tb_top;
   import subx_pkg::*;
   logic clock = 0, rst = 1, instr_valid = 0, wake = 0, wdt_tick = 0;
   instr_t instr = '0;
   logic instr_ready, osc_stop, busy, sleeping, exp_n, down_n;
   logic [7:0] acc, wdc, wps;
   logic [7:0] a_m = 8'h00;
   logic [7:0] dir [3];
   logic [7:0] dm [3] = '{8'hff, 8'hff, 8'hff};
   // limitation: the file ram is taken to power up cleared
   logic [7:0] mem_m [128] = '{default: 8'h00};
   logic [15:0] tv [5] = '{16'h0506, 16'h0606, 16'h2001, 16'hff00, 16'h1011};
   op_t fo [6] = '{op_file_exclusive_or, op_file_minus_acc,
      op_file_minus_acc_borrow, op_nibble_exchange,
      op_file_minus_acc_borrow, op_file_exclusive_or};
   flags_t flags;
   flags_t f_m = '0;
   int n_fail = 0, n_checks = 0;
   always #4 clock = ~clock;
   subx_exec i_dut (.clock, .rst, .instr_valid, .instr, .instr_ready, .wake,
      .wdt_tick, .acc, .flags, .expiry_flag_n(exp_n),
      .power_down_flag_n(down_n), .port_a_direction(dir[0]),
      .port_b_direction(dir[1]), .port_c_direction(dir[2]),
      .watchdog_counter(wdc), .wdt_prescaler(wps), .sleeping, .osc_stop,
      .busy);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one instruction: model first, then offer, release, compare
   task automatic run(input op_t op, input logic [7:0] k,
         input logic [6:0] ad = 7'h00, input logic df = 1'b0);
      logic [7:0] o, r;
      logic [8:0] d;
      logic [4:0] h;
      logic bw;
      o = (op inside {op_literal_minus_acc, op_literal_exclusive_or}) ?
         k : mem_m[ad];
      bw = (op == op_file_minus_acc_borrow) & ~f_m.carry;
      d = {1'b0, o} - {1'b0, a_m} - 9'(bw);
      h = {1'b0, o[3:0]} - {1'b0, a_m[3:0]} - 5'(bw);
      r = d[7:0];
      if (op inside {op_literal_exclusive_or, op_file_exclusive_or}) begin
         r = a_m ^ o;
         f_m.zero = (r == 8'h00);
      end else if (op == op_nibble_exchange) begin
         r = {o[3:0], o[7:4]};
      end else if (op != op_direction_load) begin
         f_m = '{~d[8], ~h[4], r == 8'h00};
      end
      if (op == op_direction_load) begin
         if (ad[2:0] >= 3'h5) dm[ad[2:0] - 3'h5] = a_m;
      end else if (df) begin
         mem_m[ad] = r;
      end else begin
         a_m = r;
      end
      instr_valid = 1;
      instr = '{op, k, ad, df};
      @(posedge clock) #1;
      instr_valid = 0;
      @(posedge clock) #1;
      chk(acc, a_m);
      chk({5'h00, flags}, {5'h00, f_m});
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      #1 rst = 0;
      chk(acc, acc_rst);
      chk(dir[1], dir_rst);
      chk({exp_n, down_n, flags}, 8'h18);
      $display("test reset done");
      // each borrow boundary, whole byte and low nibble
      foreach (tv[i]) begin
         run(op_literal_exclusive_or, a_m ^ tv[i][7:0]);
         run(op_literal_minus_acc, tv[i][15:8]);
      end
      $display("test literal done");
      // both address ends, both destinations, borrow carried between
      foreach (fo[i]) for (int j = 0; j < 4; j++) begin
         run(op_literal_exclusive_or, 8'(i * 53 + j * 29));
         run(fo[i], 8'h00, j[1] ? 7'h7f : 7'h00, j[0]);
      end
      $display("test file done");
      // codes 4 to 7: code 4 must leave every direction register alone, 5 to 7 load one each
      for (int c = 4; c < 8; c++) begin
         run(op_literal_exclusive_or, 8'(c * 17));
         run(op_direction_load, 8'h00, 7'(c));
         foreach (dm[p]) chk(dir[p], dm[p]);
      end
      $display("test direction done");
      // 259 ticks: one prescaler wrap, so both clears can be seen
      repeat (518) begin
         wdt_tick = ~wdt_tick;
         @(posedge clock) #1;
      end
      chk(wdc, 8'h01);
      chk(wps, 8'h03);
      instr_valid = 1;
      instr = '{op_sleep, 8'h00, 7'h00, 1'b0};
      @(posedge clock) #1;
      instr_valid = 0;
      chk({busy, instr_ready}, 8'h02);
      @(posedge clock) #1;
      chk({sleeping, osc_stop, exp_n, down_n, instr_ready}, 8'h1c);
      chk(wdc, wdt_clear);
      chk(wps, pre_clear);
      wake = 1;
      @(posedge clock) #1;
      wake = 0;
      chk({sleeping, instr_ready}, 8'h01);
      run(op_literal_exclusive_or, 8'h5a);
      $display("test sleep done");
      conclude();
   end
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
endmodule
bind subx_exec subx_exec_chk i_chk (.clock, .rst, .instr_valid, .instr,
   .instr_ready, .acc, .flags, .expiry_flag_n, .power_down_flag_n,
   .port_a_direction, .watchdog_counter, .wdt_prescaler, .sleeping);
